/* pkg/scadc_pkg.sv */
// Constants, field layout and state types of the scanning converter block.
// Assumes a 100 MHz clock and a 16-bit Avalon-MM master with waitrequest.
package scadc_pkg;

  localparam int CLK_HZ       = 100_000_000;
  localparam int CONV_RATE_HZ = 40_000;
  localparam int CONV_CYCLES  = CLK_HZ / CONV_RATE_HZ;
  localparam int TICK_W       = 12;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CONV_CYCLES - 1);

  localparam int ADC_W      = 12;
  localparam int CH_W       = 5;
  localparam int WORD_W     = 16;
  localparam int RAM_WORDS  = 31;
  localparam int FIFO_DEPTH = 32;
  localparam logic [CH_W-1:0] CH_LAST_DIFF = 5'h0F;
  localparam logic [CH_W-1:0] CH_LAST_SE   = 5'h1E;

  localparam int ADDR_MSB = 15;
  localparam int WIN_LSB  = 7;
  localparam int IDX_W    = 6;
  localparam logic [IDX_W-1:0] IDX_RES_END = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_CSR     = 6'h20;
  localparam logic [IDX_W-1:0] IDX_STAT    = 6'h21;
  localparam logic [IDX_W-1:0] IDX_REF     = 6'h22;

  localparam int CSR_W       = 4;
  localparam int CSR_LED_OFF = 0;
  localparam int CSR_SIGN    = 1;
  localparam int CSR_BIT_EN  = 2;
  localparam int CSR_SUSPEND = 3;
  localparam logic [CSR_W-1:0]  CSR_RESET = 4'h0;
  localparam logic              LED_RESET = 1'h1;
  localparam logic [ADC_W-1:0]  REF_RESET = 12'h000;

  localparam int AM_SUPER_BIT = 0;
  localparam int AM_NPRIV_BIT = 1;
  localparam int PIN_W        = 13;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } scadc_bus_t;

  typedef enum logic [2:0] {
    SEQ_WAIT = 3'h1,
    SEQ_CONV = 3'h2,
    SEQ_PUSH = 3'h4
  } scadc_seq_t;

endpackage : scadc_pkg

/* verilog/scadc_top.sv */
// Scan sequencer, result memory and bus slave of the analog input board.
// Assumes an external converter that holds its data while done is high,
// static straps on the jumper pins and an Avalon-MM master on ref_clk_i.
`timescale 1ns/1ps

module scadc_fifo #(
  parameter int W = 17,
  parameter int D = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = count != (AW+1)'(D);
  assign out_valid_o = count != '0;
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop)  rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : scadc_fifo

module scadc_top import scadc_pkg::*; (
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [15:0]       avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [15:0]       avs_writedata_i,
  input  wire logic [1:0]        avs_byteenable_i,
  input  wire logic              avs_supervisor_i,
  output logic [15:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [8:0]        jmp_base_i,
  input  wire logic [1:0]        jmp_am_i,
  input  wire logic              jmp_diff_i,
  input  wire logic              adc_done_i,
  input  wire logic [ADC_W-1:0]  adc_data_i,
  output logic                   adc_start_o,
  output logic [CH_W-1:0]        adc_chan_o,
  output logic                   bit_ref_en_o,
  output logic [ADC_W-1:0]       bit_ref_code_o,
  output logic                   fail_led_o
);
  localparam int FW = CH_W + ADC_W;

  // Pin synchronisers: a bit changes only once stages two and three agree
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] pins;
  wire  [PIN_W-1:0] pin_raw = {adc_done_i, jmp_diff_i, jmp_am_i, jmp_base_i};
  wire  [PIN_W-1:0] pin_diff = sync2 ^ sync3;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pins  <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pins  <= (sync2 & ~pin_diff) | (pins & pin_diff);
    end
  end

  wire [8:0] base_pin = pins[8:0];
  wire [1:0] am_pin   = pins[10:9];
  wire       diff_pin = pins[11];
  wire       done_lvl = pins[12];

  scadc_bus_t             bus_state;
  scadc_seq_t             seq_state;
  logic [CSR_W-1:0]       csr;
  logic                   fail_led;
  logic [ADC_W-1:0]       ref_code;
  logic [ADC_W-1:0]       ram [0:RAM_WORDS-1];
  logic [TICK_W-1:0]      tick_cnt;
  logic [CH_W-1:0]        cur_ch;
  logic [ADC_W-1:0]       adc_q;
  logic                   done_prev;
  logic                   diff_mode;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [FW-1:0]          fifo_out_data;

  // Address decode
  wire req      = avs_read_i | avs_write_i;
  wire base_hit = avs_address_i[ADDR_MSB:WIN_LSB] == base_pin;
  wire am_ok    = avs_supervisor_i ? am_pin[AM_SUPER_BIT]
                                   : am_pin[AM_NPRIV_BIT];
  wire hit      = base_hit & am_ok;
  wire [IDX_W-1:0] widx = avs_address_i[WIN_LSB-1:1];
  wire is_res   = hit & (widx < IDX_RES_END);
  wire is_csr   = hit & (widx == IDX_CSR);
  wire is_stat  = hit & (widx == IDX_STAT);
  wire is_ref   = hit & (widx == IDX_REF);
  wire bus_idle = bus_state == BUS_IDLE;
  wire wr_fire  = (bus_state == BUS_ACK) & avs_write_i;
  wire csr_wr   = wr_fire & is_csr & avs_byteenable_i[0];

  // Whole stored word is read in one edge, never two half conversions
  wire [ADC_W-1:0]  ram_rd   = ram[widx[CH_W-1:0]];
  wire [WORD_W-1:0] res_word =
    {{(WORD_W-ADC_W){csr[CSR_SIGN] & ram_rd[ADC_W-1]}}, ram_rd};
  wire [WORD_W-1:0] csr_word =
    {12'h000, csr[CSR_W-1:1], ~fail_led};
  wire [WORD_W-1:0] stat_word =
    {9'h000, ~fifo_in_ready, diff_mode, cur_ch};
  wire [WORD_W-1:0] ref_word = {4'h0, ref_code};
  wire [WORD_W-1:0] next_rdata =
    is_res  ? res_word  :
    is_csr  ? csr_word  :
    is_stat ? stat_word :
    is_ref  ? ref_word  : 16'h0000;

  // Byte lanes merge into the reference code for D08 writes
  wire [ADC_W-1:0] next_ref = {
    avs_byteenable_i[1] ? avs_writedata_i[11:8] : ref_code[11:8],
    avs_byteenable_i[0] ? avs_writedata_i[7:0]  : ref_code[7:0]
  };

  // Bus slave: waitrequest drops for exactly one cycle per request
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state         <= BUS_IDLE;
      avs_waitrequest_o <= 1'h1;
      avs_readdata_o    <= 16'h0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (req) begin
            bus_state         <= BUS_ACK;
            avs_waitrequest_o <= 1'h0;
            avs_readdata_o    <= next_rdata;
          end
        end
        BUS_ACK: begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'h1;
        end
        default: begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'h1;
        end
      endcase
    end
  end

  // Control/status, LED and reference code; reset forces a fixed state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      csr      <= CSR_RESET;
      fail_led <= LED_RESET;
      ref_code <= REF_RESET;
    end else begin
      if (csr_wr) begin
        csr      <= {avs_writedata_i[CSR_W-1:1], 1'h0};
        fail_led <= ~avs_writedata_i[CSR_LED_OFF];
      end
      if (wr_fire & is_ref) begin
        ref_code <= next_ref;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fail_led_o     <= LED_RESET;
      bit_ref_en_o   <= 1'h0;
      bit_ref_code_o <= REF_RESET;
    end else begin
      fail_led_o     <= fail_led;
      bit_ref_en_o   <= csr[CSR_BIT_EN];
      bit_ref_code_o <= ref_code;
    end
  end

  // Aggregate rate tick, free running so the rate ignores channel count
  wire tick_hit = tick_cnt == TICK_LAST;
  wire [CH_W-1:0] last_ch = diff_mode ? CH_LAST_DIFF : CH_LAST_SE;
  wire done_rise  = done_lvl & ~done_prev;
  wire start_ok   = tick_hit & ~csr[CSR_SUSPEND] & fifo_in_ready;
  wire push_valid = seq_state == SEQ_PUSH;
  wire [CH_W-1:0] next_ch =
    (cur_ch >= last_ch) ? '0 : cur_ch + CH_W'(1);
  // A strap change mid-scan must not start a channel past the new last one
  wire [CH_W-1:0] start_ch =
    (cur_ch > last_ch) ? '0 : cur_ch;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt  <= '0;
      done_prev <= 1'h0;
      diff_mode <= 1'h0;
    end else begin
      tick_cnt  <= tick_hit ? '0 : tick_cnt + TICK_W'(1);
      done_prev <= done_lvl;
      diff_mode <= diff_pin; // Strap caught after release, not in reset
    end
  end

  // Scan sequencer: starts with cleared control bits, so no setup needed
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_state   <= SEQ_WAIT;
      cur_ch      <= '0;
      adc_q       <= '0;
      adc_start_o <= 1'h0;
      adc_chan_o  <= '0;
    end else begin
      adc_start_o <= 1'h0;
      case (seq_state)
        SEQ_WAIT: begin
          if (start_ok) begin
            seq_state   <= SEQ_CONV;
            adc_start_o <= 1'h1;
            adc_chan_o  <= start_ch;
            cur_ch      <= start_ch;
          end
        end
        SEQ_CONV: begin
          if (done_rise) begin
            seq_state <= SEQ_PUSH;
            adc_q     <= adc_data_i;
          end
        end
        SEQ_PUSH: begin
          if (fifo_in_ready) begin
            seq_state <= SEQ_WAIT;
            cur_ch    <= next_ch;
          end
        end
        default: begin
          seq_state <= SEQ_WAIT;
        end
      endcase
    end
  end

  // A full FIFO holds the sequencer in PUSH and blocks new starts
  scadc_fifo #(
    .W (FW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({cur_ch, adc_q}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (bus_idle),
    .out_data_o  (fifo_out_data)
  );

  // Drain pauses while the bus answers, but a read taken in idle can
  // share its edge with a drain write, so the memory may see two accesses
  wire             drain_fire = fifo_out_valid & bus_idle;
  wire [CH_W-1:0]  drain_ch   = fifo_out_data[FW-1:ADC_W];
  wire [ADC_W-1:0] drain_dat  = fifo_out_data[ADC_W-1:0];

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        ram[i] <= '0;
      end
    end else if (drain_fire) begin
      ram[drain_ch] <= drain_dat;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_req_taken;
    bus_idle && req;
  endsequence

  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  a_bus_answer: assert property (s_req_taken |=> s_answer)
    else $error("bus request not answered in one cycle");

  a_scan_start: assert property (
    seq_state == SEQ_WAIT && start_ok
      |=> adc_start_o && adc_chan_o == $past(start_ch))
    else $error("scan did not start on tick");

  a_start_tick: assert property (adc_start_o |-> $past(tick_hit))
    else $error("conversion started off the rate tick");

  a_chan_range: assert property (adc_start_o |-> adc_chan_o <= last_ch)
    else $error("channel beyond configured count");

  a_ram_store: assert property (
    drain_fire |=> ram[$past(drain_ch)] == $past(drain_dat))
    else $error("result not stored");

  a_sign_fill: assert property (
    s_req_taken ##0 (is_res && avs_read_i && csr[CSR_SIGN])
      |=> avs_readdata_o[15:12] == {4{avs_readdata_o[11]}})
    else $error("sign fill wrong");

  a_word_whole: assert property (
    bus_idle && avs_read_i && is_res
      |=> avs_readdata_o[11:0] == $past(ram_rd))
    else $error("read word not a single result");

  a_decode_miss: assert property (
    bus_idle && avs_read_i && !hit
      |=> avs_readdata_o == 16'h0000)
    else $error("access outside window answered with data");

  a_led_hold: assert property ($fell(fail_led_o) |-> $past(csr_wr, 2))
    else $error("fail LED went out without a write");

  a_ref_cmd: assert property ($rose(bit_ref_en_o) |-> $past(csr_wr, 2))
    else $error("test reference enabled without command");

endmodule : scadc_top

/* tb/scadc_adc_model.sv */
// Converter model on the far side of the start/done link.
// Assumes starts arrive no faster than one per conversion time.
`timescale 1ns/1ps

module scadc_adc_model import scadc_pkg::*; (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             start_i,
  input  wire logic [CH_W-1:0]  chan_i,
  output logic                  done_o,
  output logic [ADC_W-1:0]      data_o
);
  logic [ADC_W-1:0] last;
  logic             slow;
  int               cnt;
  int               wait_n;

  // Odd pairs of channels answer slowly, the rest promptly
  assign wait_n = slow ? 40 : 6;
  assign done_o = (cnt > wait_n);
  // Data holds only while done is high, then shows its inverse
  assign data_o = done_o ? last : ~last;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt  <= 0;
      last <= 12'h000;
      slow <= 1'h0;
    end else if (start_i) begin
      cnt  <= 1;
      slow <= chan_i[1];
      // One 12-bit result per start
      last <= {chan_i[0], 6'h15, chan_i};
    end else if (cnt > 0) begin
      cnt <= (cnt > wait_n + 8) ? 0 : cnt + 1;
    end
  end
endmodule : scadc_adc_model

/* tb/testbench.sv */
// Self-checking bench for the scanning converter block.
// Assumes the converter model beside it and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module testbench import scadc_pkg::*;;
  localparam logic [15:0] BASE = 16'h3A00;
  localparam logic [15:0] CSR  = BASE + 16'h0040;
  localparam logic [15:0] REFW = BASE + 16'h0044;
  logic ref_clk_i, arst_n_i, rd, wr, sup, wreq, diff, done, start, led, ren;
  logic [15:0]      ad, wd, rdata, r;
  logic [1:0]       ben, am;
  logic [8:0]       base;
  logic [ADC_W-1:0] adata, code;
  logic [CH_W-1:0]  chan, exp_ch;
  int               bad_count, compares, starts, cyc, c_last;
  bit               susp;

  scadc_top uut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(ben), .avs_supervisor_i(sup),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .jmp_base_i(base),
    .jmp_am_i(am), .jmp_diff_i(diff), .adc_done_i(done),
    .adc_data_i(adata), .adc_start_o(start), .adc_chan_o(chan),
    .bit_ref_en_o(ren), .bit_ref_code_o(code), .fail_led_o(led));

  scadc_adc_model adc (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .start_i(start), .chan_i(chan), .done_o(done), .data_o(adata));

  initial begin
    ref_clk_i = 1'h0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // One bus access; the bench watchdog is the only limit on the wait
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] be, input logic s);
    @(posedge ref_clk_i);
    rd  <= ~w;
    wr  <= w;
    ad  <= a;
    wd  <= d;
    ben <= be;
    sup <= s;
    do @(posedge ref_clk_i); while (wreq !== 1'h0);
    r = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : acc

  // Two settle cycles so registered side effects are visible
  task automatic wr_reg(input logic [15:0] a, d, input logic [1:0] be);
    acc(1'h1, a, d, be, 1'h1);
    repeat (2) @(negedge ref_clk_i);
  endtask : wr_reg

  task automatic chk(input logic [15:0] a, input logic s,
                     input logic [15:0] e, input string nm);
    acc(1'h0, a, 16'h0000, 2'h3, s);
    `CHK(nm, e, r)
  endtask : chk

  function automatic logic [15:0] res(input logic [4:0] c, input logic f);
    logic [11:0] d;
    d = {c[0], 6'h15, c};
    return {{4{d[11] & f}}, d};
  endfunction : res

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  always @(negedge ref_clk_i) begin
    if (start === 1'h1) begin
      `CHK("chan", exp_ch, chan)
      if (starts > 0) `CHK("gap", CONV_CYCLES, cyc - c_last)
      if (susp) `CHK("suspended", 1'h0, 1'h1)
      c_last = cyc;
      starts++;
      exp_ch = (exp_ch == CH_LAST_SE) ? 5'h00 : exp_ch + 5'h01;
    end
  end

  initial begin
    #950_000;
    bad_count++;
    give_verdict();
  end

  initial begin
    {arst_n_i, rd, wr, ad, wd, ben, cyc, starts, exp_ch, susp} = '0;
    sup = 1'h1;
    base = 9'h074;
    am = 2'h3;
    diff = 1'h0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    `CHK("fail_led", 1'h1, led)
    `CHK("ref_en", 1'h0, ren)
    chk(CSR, 1'h1, 16'h0000, "csr_reset");
    $display("test reset done");
    wr_reg(CSR, 16'h0006, 2'h2);
    chk(CSR, 1'h1, 16'h0000, "csr_high_lane");
    wr_reg(CSR, 16'h0006, 2'h3);
    chk(CSR, 1'h1, 16'h0006, "csr_word");
    `CHK("led_held", 1'h1, led)
    `CHK("ref_on", 1'h1, ren)
    wr_reg(REFW, 16'hFF34, 2'h1);
    wr_reg(REFW, 16'h0A00, 2'h2);
    `CHK("ref_code", 12'hA34, code)
    wr_reg(CSR, 16'h0003, 2'h1);
    `CHK("led_off", 1'h0, led)
    `CHK("ref_off", 1'h0, ren)
    $display("test registers done");
    chk(CSR + 16'h0080, 1'h1, 16'h0000, "other_base");
    chk(CSR - 16'h2000, 1'h1, 16'h0000, "other_bit13");
    chk(BASE + 16'h0046, 1'h1, 16'h0000, "unmapped");
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      am <= (k == 0) ? 2'h1 : (k == 1) ? 2'h2 : 2'h3;
      repeat (5) @(posedge ref_clk_i);
      chk(CSR, 1'h1, k == 1 ? 16'h0000 : 16'h0003, "super");
      chk(CSR, 1'h0, k == 0 ? 16'h0000 : 16'h0003, "nonpriv");
    end
    $display("test decode done");
    while (starts < 32) @(posedge ref_clk_i);
    for (int c = 0; c < 31; c++) begin
      chk(BASE + 16'(2 * c), 1'h1, res(5'(c), 1'h1), "result");
    end
    chk(BASE + 16'h003E, 1'h1, 16'h0000, "past_last");
    wr_reg(CSR, 16'h0001, 2'h1);
    chk(BASE + 16'h0002, 1'h1, res(5'h01, 1'h0), "no_fill");
    chk(BASE + 16'h0003, 1'h1, res(5'h01, 1'h0), "odd_byte");
    $display("test scan done");
    wr_reg(CSR, 16'h0009, 2'h1);
    susp = 1'h1;
    repeat (3000) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    diff <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
    acc(1'h0, BASE + 16'h0042, 16'h0000, 2'h3, 1'h1);
    `CHK("diff_mode", 16'h0020, r & 16'h0020)
    $display("test suspend done");
    give_verdict();
  end
endmodule : testbench
